// >>> core/sertx_top.sv
// Serial transmit control and status block with its transmit queue
// What this block does
// - Transmit enable bit 5 set turns the transmitter on, clear turns it off.
// - Mode bit 4 set selects synchronous operation, clear selects asynchronous.
// - Async break request bit 3 sends break next; hardware clears; ignored in sync.
// - Break request bit reading zero means no break is pending any longer.
// - Shift empty bit 1 reads one when shift register empty, zero while shifting.
// - Nine-bit mode sends ninth bit 0 after the eight data bits.
// - In sync mode, either receive enable overrides transmit enable.
`timescale 1ns/1ps
`default_nettype none

// Transmit queue with valid and ready on both sides
module sertx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Storage write
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : sertx_fifo

module sertx_top
    import sertx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial pins
    output sertx_pins_s pins
);
    sertx_ctrl_s ctrl_reg;
    logic [1:0] rx_en_reg;
    logic [SERTX_DIV_W-1:0] div_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic wr_ok;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [SERTX_DATA_W-1:0] fifo_out_data;
    sertx_state_e state_reg;
    logic [SERTX_FRAME_W-1:0] shift_reg;
    logic [3:0] bits_left_reg;
    logic [SERTX_CNT_W-1:0] baud_cnt_reg;
    logic [SERTX_CNT_W-1:0] period;
    logic baud_tick;
    logic tx_active;
    logic start_frame;
    logic send_break;
    logic break_reg;
    logic break_done;
    logic break_frame_reg;
    logic data_hit;

    // Receive enables steal the port from the transmitter in sync mode
    assign tx_active = ctrl_reg.tx_enable
        && !(ctrl_reg.sync_mode && (rx_en_reg != 2'b00));

    // Bus answer: one wait cycle, longer while the queue is full
    assign data_hit = avs_write && (avs_address == SERTX_ADDR_DATA);
    assign wr_ok = avs_write && ack_reg;
    assign avs_waitrequest = !ack_reg;
    assign avs_readdata = rdata_reg;
    assign fifo_in_valid = data_hit && ack_reg;

    // Acknowledge strobe, held off while a data write meets a full queue
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= (avs_read || avs_write) && !ack_reg
                && !(data_hit && !fifo_in_ready);
        end
    end

    // Read data mux, zero for unmapped addresses
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            case (avs_address)
                SERTX_ADDR_CTRL: rdata_reg <= {24'h00_0000, ctrl_reg[7:4],
                    break_reg, ctrl_reg[2:0]};
                SERTX_ADDR_RXEN: rdata_reg <= {30'h0000_0000, rx_en_reg};
                SERTX_ADDR_BAUD: rdata_reg <= {16'h0000, div_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Writable control bits; the shift empty flag follows the shifter
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= SERTX_CTRL_RESET;
        end
        else
        begin
            ctrl_reg.shift_empty_flag <= (state_reg == SERTX_IDLE) && !start_frame;
            if (wr_ok && avs_address == SERTX_ADDR_CTRL)
            begin
                ctrl_reg.clock_source_master <= avs_writedata[7];
                ctrl_reg.nine_bit_tx_select <= avs_writedata[6];
                ctrl_reg.tx_enable <= avs_writedata[5];
                ctrl_reg.sync_mode <= avs_writedata[4];
                ctrl_reg.high_speed_baud_select <= avs_writedata[2];
                ctrl_reg.ninth_tx_bit <= avs_writedata[0];
            end
        end
    end

    // Receive enables and baud divisor
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rx_en_reg <= 2'b00;
            div_reg <= SERTX_DIV_RESET;
        end
        else if (wr_ok)
        begin
            if (avs_address == SERTX_ADDR_RXEN)
            begin
                rx_en_reg <= {avs_writedata[SERTX_RX_CONT_BIT],
                    avs_writedata[SERTX_RX_SINGLE_BIT]};
            end
            if (avs_address == SERTX_ADDR_BAUD)
            begin
                div_reg <= avs_writedata[SERTX_DIV_W-1:0];
            end
        end
    end

    // Break pending flag shown as control bit 3; a software write wins
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            break_reg <= 1'b0;
        end
        else if (wr_ok && avs_address == SERTX_ADDR_CTRL)
        begin
            break_reg <= avs_writedata[3];
        end
        else if (break_done)
        begin
            break_reg <= 1'b0;
        end
    end

    // Transmit queue between the data register and the shifter
    sertx_fifo #(
        .WIDTH(SERTX_DATA_W),
        .DEPTH(SERTX_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(avs_writedata[SERTX_DATA_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Bit period: x4 for high speed or sync, x16 for low speed async
    always_comb
    begin
        if (ctrl_reg.sync_mode || ctrl_reg.high_speed_baud_select)
        begin
            period = SERTX_CNT_W'({1'b0, div_reg} + 17'h0_0001) << SERTX_SHIFT_HIGH;
        end
        else
        begin
            period = SERTX_CNT_W'({1'b0, div_reg} + 17'h0_0001) << SERTX_SHIFT_LOW;
        end
    end

    // Frame start and break selection
    assign start_frame = (state_reg == SERTX_IDLE) && tx_active && fifo_out_valid;
    assign send_break = break_reg && !ctrl_reg.sync_mode;
    assign fifo_out_ready = start_frame;
    // Greater-or-equal keeps a mid-frame period change from running away
    assign baud_tick = (baud_cnt_reg >= period - 1'b1);
    // Only the end of a real break frame clears the request
    assign break_done = (state_reg == SERTX_SHIFT) && baud_tick
        && (bits_left_reg == 4'h1) && break_frame_reg;

    // Baud counter, restarted with each frame
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            baud_cnt_reg <= '0;
        end
        else if (state_reg == SERTX_IDLE || baud_tick)
        begin
            baud_cnt_reg <= '0;
        end
        else
        begin
            baud_cnt_reg <= baud_cnt_reg + 1'b1;
        end
    end

    // Shifter: loads a frame LSB first and moves one bit per tick
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_reg <= SERTX_IDLE;
            shift_reg <= '1;
            bits_left_reg <= 4'h0;
            break_frame_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                SERTX_IDLE:
                begin
                    shift_reg <= '1;
                    if (start_frame)
                    begin
                        state_reg <= SERTX_SHIFT;
                        break_frame_reg <= send_break;
                        if (ctrl_reg.sync_mode)
                        begin
                            shift_reg <= {5'h1F, ctrl_reg.ninth_tx_bit, fifo_out_data};
                            bits_left_reg <= ctrl_reg.nine_bit_tx_select
                                ? SERTX_LEN_SYNC9 : SERTX_LEN_SYNC8;
                        end
                        else if (send_break)
                        begin
                            shift_reg <= {1'b1, 13'h0000};
                            bits_left_reg <= SERTX_LEN_BREAK;
                        end
                        else if (ctrl_reg.nine_bit_tx_select)
                        begin
                            shift_reg <= {4'hF, ctrl_reg.ninth_tx_bit,
                                fifo_out_data, 1'b0};
                            bits_left_reg <= SERTX_LEN_ASYNC9;
                        end
                        else
                        begin
                            shift_reg <= {5'h1F, fifo_out_data, 1'b0};
                            bits_left_reg <= SERTX_LEN_ASYNC8;
                        end
                    end
                end
                SERTX_SHIFT:
                begin
                    if (baud_tick)
                    begin
                        shift_reg <= {1'b1, shift_reg[SERTX_FRAME_W-1:1]};
                        bits_left_reg <= bits_left_reg - 1'b1;
                        if (bits_left_reg == 4'h1)
                        begin
                            state_reg <= SERTX_IDLE;
                        end
                    end
                end
                default: state_reg <= SERTX_IDLE;
            endcase
        end
    end

    // Pins: line from the shifter, sync clock driven only in sync master mode
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pins <= 3'b100;
        end
        else
        begin
            pins.tx_line <= (state_reg == SERTX_SHIFT) ? shift_reg[0] : 1'b1;
            pins.sync_clk_out <= (state_reg == SERTX_SHIFT)
                && (baud_cnt_reg >= (period >> 1));
            pins.sync_clk_oe <= ctrl_reg.sync_mode && ctrl_reg.clock_source_master
                && tx_active;
        end
    end
endmodule : sertx_top

`default_nettype wire

// >>> core/sertx_pkg.sv
// Package with register map, field layout and timing constants of the block
package sertx_pkg;
    // Register byte addresses on the word-aligned bus
    localparam logic [3:0] SERTX_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SERTX_ADDR_DATA = 4'h4;
    localparam logic [3:0] SERTX_ADDR_RXEN = 4'h8;
    localparam logic [3:0] SERTX_ADDR_BAUD = 4'hC;
    // Control register reset value: only the shift empty flag set
    localparam logic [7:0] SERTX_CTRL_RESET = 8'h02;
    // Bit positions in the receive enable register
    localparam int SERTX_RX_SINGLE_BIT = 0;
    localparam int SERTX_RX_CONT_BIT = 1;
    // Baud divisor width and reset value
    localparam int SERTX_DIV_W = 16;
    localparam logic [15:0] SERTX_DIV_RESET = 16'h0000;
    // Clock division shifts: x4 high speed and sync, x16 low speed
    localparam int SERTX_SHIFT_HIGH = 2;
    localparam int SERTX_SHIFT_LOW = 4;
    localparam int SERTX_CNT_W = SERTX_DIV_W + SERTX_SHIFT_LOW + 1;
    // Frame lengths in bit times
    localparam int SERTX_FRAME_W = 14;
    localparam logic [3:0] SERTX_LEN_ASYNC8 = 4'hA;
    localparam logic [3:0] SERTX_LEN_ASYNC9 = 4'hB;
    localparam logic [3:0] SERTX_LEN_SYNC8 = 4'h8;
    localparam logic [3:0] SERTX_LEN_SYNC9 = 4'h9;
    localparam logic [3:0] SERTX_LEN_BREAK = 4'hE;
    // Words held in the transmit queue
    localparam int SERTX_FIFO_DEPTH = 8;
    localparam int SERTX_DATA_W = 8;

    // Control and status register fields, bit 7 down to bit 0
    typedef struct packed {
        logic clock_source_master;
        logic nine_bit_tx_select;
        logic tx_enable;
        logic sync_mode;
        logic break_request;
        logic high_speed_baud_select;
        logic shift_empty_flag;
        logic ninth_tx_bit;
    } sertx_ctrl_s;

    // Serial pin group driven by the block
    typedef struct packed {
        logic tx_line;
        logic sync_clk_out;
        logic sync_clk_oe;
    } sertx_pins_s;

    // Transmitter states
    typedef enum logic [0:0] {
        SERTX_IDLE,
        SERTX_SHIFT
    } sertx_state_e;
endpackage : sertx_pkg

// >>> dv/sertx_top_asserts.sv
// Checker of bus answer timing and serial pin behaviour
`timescale 1ns/1ps
`default_nettype none
module sertx_top_asserts
    import sertx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins
    input wire sertx_pins_s pins
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Control read completing at this edge
    wire logic ctl_rd;
    assign ctl_rd = avs_read && !avs_waitrequest
        && avs_address == SERTX_ADDR_CTRL;
    property p_ans;
        (avs_read || avs_write) && avs_waitrequest
            && avs_address != SERTX_ADDR_DATA |=> !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
    property p_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_one: assert property (p_one) else $error("ack too long");
    property p_unmap;
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
            |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_busy;
        ctl_rd && !pins.tx_line && !$past(pins.tx_line) |-> !avs_readdata[1];
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag");
    property p_off;
        ctl_rd && !avs_readdata[5] && avs_readdata[1] |-> pins.tx_line;
    endproperty
    a_off: assert property (p_off) else $error("line busy");
    property p_async;
        ctl_rd && !avs_readdata[4] |-> !pins.sync_clk_oe;
    endproperty
    a_async: assert property (p_async) else $error("clock on");
    property p_low;
        $fell(pins.tx_line) |-> !pins.tx_line [*4];
    endproperty
    a_low: assert property (p_low) else $error("short low");
    property p_high;
        $rose(pins.tx_line) |-> pins.tx_line [*4];
    endproperty
    a_high: assert property (p_high) else $error("short high");
endmodule : sertx_top_asserts
`default_nettype wire

// >>> dv/sertx_rx_model.sv
// Remote asynchronous receiver that records each frame
`timescale 1ns/1ps
`default_nettype none
module sertx_rx_model (
    // Clock
    input wire logic clk_sys,
    // Line and frame format
    input wire logic line,
    input wire logic [7:0] period,
    input wire logic nine
);
    logic [8:0] got[$];
    logic [8:0] sh;
    int ferr = 0;
    // Start edge, mid-bit sampling, stop check
    initial forever
    begin
        @(negedge clk_sys);
        if (line === 1'b0)
        begin
            sh = 9'h000;
            repeat (period / 2) @(negedge clk_sys);
            for (int i = 0; i < 8 + nine; i++)
            begin
                repeat (period) @(negedge clk_sys);
                sh[i] = line;
            end
            repeat (period) @(negedge clk_sys);
            ferr += (line !== 1'b1);
            got.push_back(sh);
            while (line !== 1'b1) @(negedge clk_sys);
        end
    end
endmodule : sertx_rx_model
`default_nettype wire

// >>> dv/sertx_top_tb.sv
// Bench for the serial transmit control block
`timescale 1ns/1ps
`default_nettype none
module sertx_top_tb
    import sertx_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdat, got;
    sertx_pins_s pins;
    logic [7:0] per = 8'h04;
    logic nine = 1'b0;
    int err_total = 0, samples_checked = 0, cyc = 0, waits, hi, ck;
    sertx_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wreq), .pins(pins));
    sertx_rx_model peer (.clk_sys(clk_sys), .line(pins.tx_line),
        .period(per), .nine(nine));
    // Clock and hang guard
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
            results(1);
    end
    // One bus cycle, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic [3:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk_sys);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        waits = 0;
        @(posedge clk_sys);
        while (wreq !== 1'b0)
        begin
            waits++;
            @(posedge clk_sys);
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic check(input logic [31:0] e, input logic [31:0] a);
        samples_checked++;
        if (a !== e)
        begin
            err_total++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask : check
    // Waits for frames, or counts sync clock enable cycles
    task automatic frames(input int n);
        repeat (3000) if (peer.got.size() < n) @(posedge clk_sys);
        repeat (10) @(posedge clk_sys);
    endtask : frames
    task automatic watch(input int n);
        hi = 0;
        ck = 0;
        repeat (n)
        begin
            @(negedge clk_sys);
            hi += pins.sync_clk_oe;
            ck += pins.sync_clk_out;
        end
    endtask : watch
    task automatic results(input int bad);
        err_total += bad;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Test sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(SERTX_ADDR_CTRL, 1'b0, 32'h0);
        check(32'h0000_0002, got);
        bus(SERTX_ADDR_BAUD, 1'b1, 32'h0);
        bus(SERTX_ADDR_CTRL, 1'b1, 32'h0000_0004);
        bus(SERTX_ADDR_CTRL, 1'b0, 32'h0);
        check(32'h0000_0006, got);
        bus(4'h2, 1'b1, 32'hFFFF_FFFF);
        bus(4'h2, 1'b0, 32'h0);
        check(32'h0, got);
        $display("test reset done");
        bus(SERTX_ADDR_DATA, 1'b1, 32'h0000_0055);
        repeat (100) @(posedge clk_sys);
        check(32'h0, peer.got.size());
        bus(SERTX_ADDR_CTRL, 1'b1, 32'h0000_0024);
        bus(SERTX_ADDR_CTRL, 1'b0, 32'h0);
        check(32'h0000_0024, got);
        frames(1);
        check(32'h0000_0055, peer.got[0]);
        bus(SERTX_ADDR_CTRL, 1'b0, 32'h0);
        check(32'h0000_0026, got);
        $display("test enable done");
        nine <= 1'b1;
        for (int b = 0; b < 2; b++)
        begin
            bus(SERTX_ADDR_CTRL, 1'b1, 32'h0000_0064 | b);
            bus(SERTX_ADDR_DATA, 1'b1, 32'h0000_00A3);
            frames(2 + b);
            check({b[0], 8'hA3}, peer.got[1 + b]);
        end
        $display("test ninth bit done");
        nine <= 1'b0;
        per <= 8'd16;
        bus(SERTX_ADDR_CTRL, 1'b1, 32'h0000_0020);
        bus(SERTX_ADDR_DATA, 1'b1, 32'h0000_0096);
        frames(4);
        check(32'h0000_0096, peer.got[3]);
        $display("test low speed done");
        per <= 8'd4;
        bus(SERTX_ADDR_CTRL, 1'b1, 32'h0000_002C);
        bus(SERTX_ADDR_CTRL, 1'b0, 32'h0);
        check(32'h0000_002E, got);
        bus(SERTX_ADDR_DATA, 1'b1, 32'h0);
        bus(SERTX_ADDR_DATA, 1'b1, 32'h0000_0081);
        frames(6);
        check(32'h0000_0001, peer.ferr);
        check(32'h0000_0081, peer.got[5]);
        bus(SERTX_ADDR_CTRL, 1'b0, 32'h0);
        check(32'h0000_0026, got);
        $display("test break done");
        for (int k = 0; k < 10; k++)
            bus(SERTX_ADDR_DATA, 1'b1, 32'h0000_0010 + k);
        check(32'h1, waits > 4);
        frames(16);
        for (int k = 0; k < 10; k++)
            check(32'h0000_0010 + k, peer.got[6 + k]);
        $display("test queue done");
        for (int c = 1; c < 4; c++)
        begin
            bus(SERTX_ADDR_RXEN, 1'b1, c);
            if (c == 1)
                bus(SERTX_ADDR_CTRL, 1'b1, 32'h0000_00B0);
            if (c == 1)
                bus(SERTX_ADDR_DATA, 1'b1, 32'h0000_005A);
            watch(60);
            check(32'h0, hi);
            check(32'h0, ck);
        end
        bus(SERTX_ADDR_RXEN, 1'b1, 32'h0);
        watch(60);
        check(32'h1, hi > 0);
        check(32'h1, ck > 0);
        $display("test sync done");
        results(0);
    end
endmodule : sertx_top_tb
bind sertx_top sertx_top_asserts chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pins(pins));
`default_nettype wire
